// ---- hw/sio8.sv ----
// Clock-synchronous 8-bit serial interface with APB register access
//
// Contract
// - Internal clock offers seven divided rates, driven out on clock pin.
// - Internal clock pin driven high when a transfer starts.
// - Internal clock halts until pending buffer write or read is done.
// - Clock source code 111 uses the clock pin input as shift clock.
// - Output changes on falling edge, input captured on rising edge.
// - Transfer mode field picks transmit, receive or both.
// - Transmit loads buffer into shifter, sent LSB first after start.
// - Buffer load into shifter marks buffer empty and raises request.
// - Internal clock transmit stalls after 8 bits until buffer written.
// - Serial output holds last bit until next falling clock edge.
// - Clearing start finishes pending data, then clears active flag.
// - Setting abort stops at once and clears active flag.
// - Receive shifts LSB first; after 8 bits fills buffer, raises request.
// - Internal clock receive stalls until received byte is read.
// - Clearing start ends receive at byte end; aborted data invalid.
// - Mode change during receive discards the buffer contents.
// - Both-way mode sends and samples, stores byte, requests after 8.
// - Internal clock both-way stalls until read done and write done.
// - Idle bit stops (0) or runs (1) during processor idle.
// - Baud clock enable stops or runs internal clock source.
// - Interface mode selects port, serial or two-wire; only serial runs.
`timescale 1ns/1ps
`default_nettype none
module sio8 #(
   parameter int ADDR_W   = 12,
   parameter int DIV_BASE = 4
) (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   // Processor idle state
   input  wire logic              cpu_idle,
   // Serial pins
   input  wire logic              sck_i,
   output logic                   sck_o,
   output logic                   sck_oe,
   output logic                   so_o,
   input  wire logic              si_i,
   // Event requests
   output logic                   buffer_event_irq,
   output logic                   serial_event_irq
);

   // Register state
   sio_pkg::ctrl_s      ctrl_ff;
   logic [1:0]          ifm_ff;
   logic                idle_run_ff;
   logic                baud_en_ff;
   logic [7:0]          buf_ff;
   logic                tx_pend_ff;
   logic                rx_unread_ff;
   // Engine state
   sio_pkg::xfer_state_e state_ff;
   logic [7:0]          sh_ff;
   logic [3:0]          bit_cnt_ff;
   logic                sck_ff;
   logic                sck_oe_ff;
   logic                so_ff;
   logic                bev_ff;
   logic                sev_ff;
   logic                dummy_ff;
   // APB answer state
   logic                pready_ff;
   logic [31:0]         prdata_ff;
   logic                pslverr_ff;
   // Synchronisers
   logic [1:0]          sck_sync_ff;
   logic                sck_prev_ff;
   logic [1:0]          si_sync_ff;
   // Divider
   logic [15:0]         div_cnt_ff;

   // Word index match against a printed offset
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [31:0] off);
      hit = (a[ADDR_W-1:2] == off[ADDR_W-3:0]);
   endfunction

   // Decode
   logic acc;
   logic wr;
   logic rd;
   logic hit_ctl;
   logic hit_buf;
   logic hit_st;
   logic hit_idle;
   logic hit_clk;
   logic mapped;
   assign acc      = psel & penable & pready_ff;
   assign wr       = acc & pwrite;
   assign rd       = acc & ~pwrite;
   assign hit_ctl  = hit(paddr, sio_pkg::OFF_CONTROL_ONE);
   assign hit_buf  = hit(paddr, sio_pkg::OFF_DATA_BUFFER);
   assign hit_st   = hit(paddr, sio_pkg::OFF_STATUS);
   assign hit_idle = hit(paddr, sio_pkg::OFF_IDLE_CTRL);
   assign hit_clk  = hit(paddr, sio_pkg::OFF_CLOCK_EN);
   assign mapped   = hit_ctl | hit_buf | hit_st | hit_idle | hit_clk;

   // Incoming control word
   sio_pkg::ctrl_s wctl;
   assign wctl = '{start:   pwdata[sio_pkg::CTL_START_BIT],
                   abort:   pwdata[sio_pkg::CTL_ABORT_BIT],
                   mode:    pwdata[sio_pkg::CTL_MODE_LSB +: 2],
                   clk_sel: pwdata[sio_pkg::CTL_CLK_LSB +: 3]};

   // Mode and gating terms
   logic ext_clk;
   logic sio_on;
   logic run_ok;
   logic active;
   logic m_tx;
   logic m_rx;
   logic m_txrx;
   assign ext_clk = (ctrl_ff.clk_sel == sio_pkg::CLK_EXTERNAL);
   assign sio_on  = (ifm_ff == sio_pkg::IFM_SIO);
   assign run_ok  = sio_on & ~(cpu_idle & ~idle_run_ff);
   assign active  = (state_ff == sio_pkg::ST_RUN);
   assign m_tx    = (ctrl_ff.mode == sio_pkg::XM_TX);
   assign m_rx    = (ctrl_ff.mode == sio_pkg::XM_RX);
   assign m_txrx  = (ctrl_ff.mode == sio_pkg::XM_TXRX);

   // APB answer: one wait state, then data and error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff  <= psel & penable & ~pready_ff;
         pslverr_ff <= psel & penable & ~pready_ff & ~mapped;
         prdata_ff  <= 32'h0000_0000;
         if (psel & penable & ~pready_ff & ~pwrite) begin
            if (hit_ctl)
               prdata_ff <= {24'h00_0000, ctrl_ff.start, ctrl_ff.abort,
                             ctrl_ff.mode, 1'b0, ctrl_ff.clk_sel};
            else if (hit_buf)
               prdata_ff <= {24'h00_0000, buf_ff};
            else if (hit_st) begin
               prdata_ff[sio_pkg::ST_ACTIVE_BIT] <= active;
               prdata_ff[sio_pkg::ST_SHIFT_BIT]  <= (bit_cnt_ff != 4'h0);
            end else if (hit_idle)
               prdata_ff[sio_pkg::IDLE_RUN_BIT] <= idle_run_ff;
            else if (hit_clk)
               prdata_ff[sio_pkg::BAUD_EN_BIT] <= baud_en_ff;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff     <= '0;
         ifm_ff      <= sio_pkg::IFM_PORT;
         idle_run_ff <= 1'b0;
         baud_en_ff  <= 1'b0;
      end else if (wr) begin
         if (hit_ctl)
            ctrl_ff <= wctl;
         if (hit_st)
            ifm_ff <= pwdata[sio_pkg::IFM_LSB +: 2];
         if (hit_idle)
            idle_run_ff <= pwdata[sio_pkg::IDLE_RUN_BIT];
         if (hit_clk)
            baud_en_ff <= pwdata[sio_pkg::BAUD_EN_BIT];
      end
   end

   // Pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_sync_ff <= 2'b11;
         sck_prev_ff <= 1'b1;
         si_sync_ff  <= 2'b00;
      end else begin
         sck_sync_ff <= {sck_sync_ff[0], sck_i};
         sck_prev_ff <= sck_sync_ff[1];
         si_sync_ff  <= {si_sync_ff[0], si_i};
      end
   end

   // Baud divider: half period is DIV_BASE shifted by the rate code
   logic [15:0] half_cnt;
   logic        tick;
   assign half_cnt = 16'(DIV_BASE) << ctrl_ff.clk_sel;
   assign tick     = baud_en_ff & (div_cnt_ff == half_cnt - 16'h0001);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         div_cnt_ff <= 16'h0000;
      else if (!baud_en_ff || tick || !active)
         div_cnt_ff <= 16'h0000;
      else
         div_cnt_ff <= div_cnt_ff + 16'h0001;
   end

   // Byte-start permission (automatic wait)
   logic at_bound;
   logic data_ok;
   logic more;
   assign at_bound = (bit_cnt_ff == 4'h0);
   assign data_ok  = m_tx   ? tx_pend_ff :
                     m_rx   ? ~rx_unread_ff :
                     m_txrx ? (tx_pend_ff & ~rx_unread_ff) :
                     1'b0;
   // Further bytes wanted at a byte boundary
   assign more = ~dummy_ff &
                 (ctrl_ff.start | (m_tx & tx_pend_ff));

   // Shift clock edges from either source
   logic fall_ev;
   logic rise_ev;
   always_comb begin
      fall_ev = 1'b0;
      rise_ev = 1'b0;
      if (active && run_ok) begin
         if (ext_clk) begin
            fall_ev = sck_prev_ff & ~sck_sync_ff[1];
            rise_ev = ~sck_prev_ff & sck_sync_ff[1];
            if (at_bound && !more)
               fall_ev = 1'b0;
         end else if (tick) begin
            fall_ev = sck_ff & (~at_bound | (more & data_ok));
            rise_ev = ~sck_ff;
         end
      end
   end

   // A dummy byte on the external clock ends the transmit run
   logic dummy_go;
   assign dummy_go = fall_ev & at_bound & ext_clk & ~m_rx & ~tx_pend_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         dummy_ff <= 1'b0;
      else if (!active)
         dummy_ff <= 1'b0;
      else if (dummy_go)
         dummy_ff <= 1'b1;
   end

   // Transfer state
   logic start_wr;
   logic abort_wr;
   logic done_byte;
   assign start_wr  = wr & hit_ctl & wctl.start & ~wctl.abort;
   assign abort_wr  = wr & hit_ctl & wctl.abort;
   assign done_byte = rise_ev & (bit_cnt_ff == sio_pkg::BYTE_BITS);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         state_ff <= sio_pkg::ST_IDLE;
      else
         case (state_ff)
            sio_pkg::ST_IDLE: begin
               if (start_wr && sio_on)
                  state_ff <= sio_pkg::ST_RUN;
            end
            sio_pkg::ST_RUN: begin
               if (abort_wr || !sio_on)
                  state_ff <= sio_pkg::ST_IDLE;
               else if (at_bound && !more && !fall_ev && !rise_ev)
                  state_ff <= sio_pkg::ST_IDLE;
            end
            default: state_ff <= sio_pkg::ST_IDLE;
         endcase
   end

   // Shifter, bit counter and serial output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_ff      <= 8'h00;
         bit_cnt_ff <= 4'h0;
         so_ff      <= 1'b1;
      end else if (!active || abort_wr) begin
         bit_cnt_ff <= 4'h0;
      end else if (fall_ev) begin
         if (at_bound) begin
            // Load written byte; else shifter content goes out as dummy
            if (!m_rx && tx_pend_ff) begin
               sh_ff <= buf_ff;
               so_ff <= buf_ff[0];
            end else if (!m_rx) begin
               so_ff <= sh_ff[0];
            end
            bit_cnt_ff <= 4'h1;
         end else begin
            so_ff <= sh_ff[0];
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
         end
      end else if (rise_ev) begin
         sh_ff <= {si_sync_ff[1], sh_ff[7:1]};
         if (bit_cnt_ff == sio_pkg::BYTE_BITS)
            bit_cnt_ff <= 4'h0;
      end
   end

   // Internal clock pin: rests high, low half after each fall
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_ff    <= 1'b1;
         sck_oe_ff <= 1'b0;
      end else begin
         sck_oe_ff <= sio_on & ~ext_clk;
         if (!active || start_wr || abort_wr)
            sck_ff <= 1'b1;
         else if (!ext_clk && fall_ev)
            sck_ff <= 1'b0;
         else if (!ext_clk && rise_ev)
            sck_ff <= 1'b1;
      end
   end

   // Data buffer: bus access, load to shifter, received byte
   logic buf_rd;
   logic buf_wr;
   logic tx_load;
   logic mode_chg;
   assign buf_rd   = rd & hit_buf;
   assign buf_wr   = wr & hit_buf;
   assign tx_load  = fall_ev & at_bound & ~m_rx & tx_pend_ff;
   assign mode_chg = wr & hit_ctl & (wctl.mode != ctrl_ff.mode) &
                     active & (m_rx | m_txrx);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_ff       <= 8'h00;
         tx_pend_ff   <= 1'b0;
         rx_unread_ff <= 1'b0;
      end else begin
         if (done_byte && !m_tx)
            buf_ff <= {si_sync_ff[1], sh_ff[7:1]};
         else if (buf_wr)
            buf_ff <= pwdata[7:0];
         // A write in the load cycle wins over the load
         if (buf_wr && !m_rx)
            tx_pend_ff <= 1'b1;
         else if (tx_load)
            tx_pend_ff <= 1'b0;
         // A new byte in the read cycle wins over the read
         if (done_byte && !m_tx)
            rx_unread_ff <= 1'b1;
         else if (mode_chg)
            rx_unread_ff <= 1'b0;
         else if (buf_rd || abort_wr)
            rx_unread_ff <= 1'b0;
      end
   end

   // Event request pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bev_ff <= 1'b0;
         sev_ff <= 1'b0;
      end else begin
         bev_ff <= tx_load & m_tx;
         sev_ff <= done_byte & ~m_tx;
      end
   end

   // Outputs
   assign pready           = pready_ff;
   assign prdata           = prdata_ff;
   assign pslverr          = pslverr_ff;
   assign sck_o            = sck_ff;
   assign sck_oe           = sck_oe_ff;
   assign so_o             = so_ff;
   assign buffer_event_irq = bev_ff;
   assign serial_event_irq = sev_ff;

endmodule
`default_nettype wire

// ---- inc/sio_pkg.sv ----
// Constants and types shared by the clocked serial interface
package sio_pkg;
   // Printed register offsets (register index; byte address is 4x)
   localparam logic [31:0] OFF_CONTROL_ONE = 32'hFFFF_F240;
   localparam logic [31:0] OFF_DATA_BUFFER = 32'hFFFF_F241;
   localparam logic [31:0] OFF_STATUS      = 32'hFFFF_F243;
   localparam logic [31:0] OFF_IDLE_CTRL   = 32'hFFFF_F244;
   localparam logic [31:0] OFF_CLOCK_EN    = 32'hFFFF_F245;

   // Control one fields
   localparam int CTL_START_BIT = 7;
   localparam int CTL_ABORT_BIT = 6;
   localparam int CTL_MODE_LSB  = 4;
   localparam int CTL_CLK_LSB   = 0;
   // Status / interface mode fields (same offset)
   localparam int ST_ACTIVE_BIT = 3;
   localparam int ST_SHIFT_BIT  = 2;
   localparam int IFM_LSB       = 2;
   // Idle control and clock enable fields
   localparam int IDLE_RUN_BIT  = 6;
   localparam int BAUD_EN_BIT   = 7;

   // Field encodings
   localparam logic [2:0] CLK_EXTERNAL = 3'h7;
   localparam logic [1:0] XM_TX        = 2'h0;
   localparam logic [1:0] XM_TXRX      = 2'h2;
   localparam logic [1:0] XM_RX        = 2'h3;
   localparam logic [1:0] IFM_PORT     = 2'h0;
   localparam logic [1:0] IFM_SIO      = 2'h1;
   localparam logic [1:0] IFM_I2C      = 2'h2;

   // Bits in one byte
   localparam logic [3:0] BYTE_BITS    = 4'h8;

   typedef struct packed {
      logic       start;
      logic       abort;
      logic [1:0] mode;
      logic [2:0] clk_sel;
   } ctrl_s;

   typedef enum logic {ST_IDLE, ST_RUN} xfer_state_e;
endpackage

// ---- tb/sio8_properties.sv ----
// Port-level properties of the clocked serial interface
`timescale 1ns/1ps
`default_nettype none
module sio8_properties #(
   parameter int ADDR_W   = 12,
   parameter int DIV_BASE = 4
) (
   // Clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // APB slave
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic [31:0]       prdata,
   input wire logic              pslverr,
   // Idle, serial pins, requests
   input wire logic              cpu_idle,
   input wire logic              sck_i,
   input wire logic              sck_o,
   input wire logic              sck_oe,
   input wire logic              so_o,
   input wire logic              si_i,
   input wire logic              buffer_event_irq,
   input wire logic              serial_event_irq
);
   logic [7:0] low_cnt_ff;
   logic       unread_ff;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Length of the current low phase of the clock pin
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) low_cnt_ff <= 8'h00;
      else if (sck_o) low_cnt_ff <= 8'h00;
      else if (low_cnt_ff != 8'hFF) low_cnt_ff <= low_cnt_ff + 8'h01;

   // Received byte waiting for a register read
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) unread_ff <= 1'b0;
      else if (serial_event_irq) unread_ff <= 1'b1;
      else if (pready && !pwrite) unread_ff <= 1'b0;

   a_reset_idle: assert property ($rose(presetn) |-> sck_o && so_o)
      else $error("pins not idle after reset");
   a_start_high: assert property (pready && pwrite && sck_oe &&
      pwdata[sio_pkg::CTL_START_BIT] &&
      paddr[ADDR_W-1:2] == sio_pkg::OFF_CONTROL_ONE[ADDR_W-3:0]
      |=> sck_o)
      else $error("clock pin not high at transfer start");
   a_clock_half: assert property ($rose(sck_o) && sck_oe &&
      !$past(pready) |-> low_cnt_ff >= DIV_BASE)
      else $error("clock low phase too short");
   a_rx_wait: assert property (unread_ff && sck_oe |-> !$fell(sck_o))
      else $error("clock ran before byte was read");
   a_so_on_fall: assert property (sck_oe && $changed(so_o) &&
      !$past(pready) |-> $fell(sck_o))
      else $error("serial out changed off a falling edge");
   a_empty_req: assert property (buffer_event_irq && sck_oe |->
      $fell(sck_o))
      else $error("empty request not after a falling edge");
   a_irq_pulse: assert property (buffer_event_irq || serial_event_irq
      |=> !buffer_event_irq && !serial_event_irq)
      else $error("request longer than one cycle");
   a_apb_answer: assert property (psel && penable && !pready |=> pready)
      else $error("no ready in second access cycle");
   a_rdata_idle: assert property (!pready || pslverr |-> prdata == 32'h0)
      else $error("read data not zero");
   c_tx_req: cover property (buffer_event_irq);
   c_rx_done: cover property (serial_event_irq);
   c_unmapped: cover property (pslverr);
endmodule
bind sio8 sio8_properties #(.ADDR_W(ADDR_W), .DIV_BASE(DIV_BASE))
   sio8_properties_inst (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .prdata, .pslverr, .cpu_idle, .sck_i,
   .sck_o, .sck_oe, .so_o, .si_i, .buffer_event_irq, .serial_event_irq);
`default_nettype wire

// ---- tb/sio_peer.sv ----
// Behavioural serial peer: drives serial in, captures serial out
`timescale 1ns/1ps
`default_nettype none
module sio_peer (
   // Serial pins
   input  wire logic       sck_w,
   input  wire logic       so,
   output logic            si,
   output logic            sck_ext,
   // Test control
   input  wire logic       load,
   input  wire logic       ext_go,
   input  wire logic [7:0] tx_byte,
   output logic [7:0]      rx_byte
);
   logic [7:0] sh;

   // Own clock rests high between frames
   initial begin
      sck_ext = 1'b1;
      si = 1'b1;
      sh = 8'h00;
   end
   // One frame of eight external clocks
   always @(posedge ext_go) begin
      #3;
      repeat (8) begin
         #32 sck_ext = 1'b0;
         #32 sck_ext = 1'b1;
      end
   end
   // New outgoing byte
   always @(load) sh = tx_byte;
   // Next bit out on falling edge, LSB first; spent bits turn to noise
   always @(negedge sck_w) begin
      si = sh[0];
      sh = {~sh[0], sh[7:1]};
   end
   // Serial out captured on rising edge, LSB first
   always @(posedge sck_w) rx_byte = {so, rx_byte[7:1]};
endmodule
`default_nettype wire

// ---- tb/sio8_tb.sv ----
// Self-checking bench for the clocked serial interface
`timescale 1ns/1ps
`default_nettype none
module sio8_tb;
   localparam logic [11:0] A_CTL  = {sio_pkg::OFF_CONTROL_ONE[9:0], 2'b00};
   localparam logic [11:0] A_BUF  = {sio_pkg::OFF_DATA_BUFFER[9:0], 2'b00};
   localparam logic [11:0] A_STAT = {sio_pkg::OFF_STATUS[9:0], 2'b00};
   localparam logic [11:0] A_IDLE = {sio_pkg::OFF_IDLE_CTRL[9:0], 2'b00};
   localparam logic [11:0] A_CLK  = {sio_pkg::OFF_CLOCK_EN[9:0], 2'b00};
   typedef struct packed {
      logic [11:0] a;
      logic [7:0]  w;
      logic [7:0]  r0;
      logic [7:0]  r1;
      logic        e;
   } row_s;
   localparam row_s ROWS [4] = '{
      '{A_IDLE, 8'h40, 8'h00, 8'h40, 1'b0},
      '{A_CLK, 8'h80, 8'h00, 8'h80, 1'b0},
      '{A_STAT, 8'h04, 8'h00, 8'h00, 1'b0},
      '{12'h000, 8'hFF, 8'h00, 8'h00, 1'b1}};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        sck_o, sck_oe, sck_ext, sck_w, so, si, err;
   logic        irq_b, irq_s, load, ext_go, cpu_idle;
   logic [7:0]  tx_byte, rx_byte;
   int          err_count = 0, check_count = 0;
   int          nb = 0, ns = 0, rises = 0, b0, s0;

   sio8 sio8_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .cpu_idle(cpu_idle),
      .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .so_o(so), .si_i(si),
      .buffer_event_irq(irq_b), .serial_event_irq(irq_s));
   sio_peer sio_peer_inst (.sck_w(sck_w), .so(so), .si(si),
      .sck_ext(sck_ext), .load(load), .ext_go(ext_go),
      .tx_byte(tx_byte), .rx_byte(rx_byte));
   // Clock pin level from both drivers
   assign sck_w = sck_oe ? sck_o : sck_ext;

   // System clock
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Event counters
   always @(posedge pclk) begin
      if (irq_b === 1'b1) nb++;
      if (irq_s === 1'b1) ns++;
   end
   always @(posedge sck_w) rises++;

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer, held until ready is sampled
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
      int n;
      @(posedge pclk);
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n == 20) err_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_rises(input int k);
      int t;
      t = rises + k;
      repeat (3000) if (rises < t) @(posedge pclk);
      check(rises, t);
   endtask
   task automatic stall_chk;
      int r;
      r = rises;
      repeat (40) @(posedge pclk);
      check(rises, r);
   endtask
   task automatic final_report;
      $display("errors=%0d checks=%0d", err_count, check_count);
      if (err_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Watchdog
   initial begin
      #100000;
      err_count++;
      final_report;
   end

   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, load, ext_go, cpu_idle} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      tx_byte = 8'h00;
      repeat (16) @(posedge pclk);
      check({sck_o, so, sck_oe}, 3'h6);
      presetn <= 1'b1;
      foreach (ROWS[i]) begin
         apb(1'b0, ROWS[i].a, 8'h00);
         check(rd, ROWS[i].r0);
         apb(1'b1, ROWS[i].a, ROWS[i].w);
         check(err, ROWS[i].e);
         apb(1'b0, ROWS[i].a, 8'h00);
         check({rd[30:0], err}, {ROWS[i].r1, ROWS[i].e});
      end
      // Internal transmit, wait, then stop with a byte pending
      apb(1'b1, A_BUF, 8'hA5);
      b0 = nb;
      apb(1'b1, A_CTL, 8'h80);
      wait_rises(8);
      stall_chk;
      check(rx_byte, 8'hA5);
      check(nb - b0, 1);
      apb(1'b0, A_STAT, 8'h00);
      check(rd & 32'h08, 32'h08);
      apb(1'b1, A_BUF, 8'h96);
      apb(1'b1, A_CTL, 8'h00);
      wait_rises(8);
      stall_chk;
      check(rx_byte, 8'h96);
      apb(1'b0, A_STAT, 8'h00);
      check(rd, 0);
      // Internal receive, then abort
      apb(1'b1, A_CTL, 8'h70);
      tx_byte = 8'h3C;
      load = ~load;
      s0 = ns;
      apb(1'b1, A_CTL, 8'hB0);
      wait_rises(8);
      stall_chk;
      check(ns - s0, 1);
      apb(1'b0, A_BUF, 8'h00);
      check(rd, 32'h3C);
      apb(1'b1, A_CTL, 8'h40);
      apb(1'b0, A_STAT, 8'h00);
      check(rd, 0);
      // Transmit and receive together
      apb(1'b1, A_CTL, 8'h60);
      apb(1'b1, A_BUF, 8'h5A);
      tx_byte = 8'hC3;
      load = ~load;
      apb(1'b1, A_CTL, 8'hA0);
      wait_rises(8);
      stall_chk;
      apb(1'b0, A_BUF, 8'h00);
      check(rd, 32'hC3);
      stall_chk;
      check(rx_byte, 8'h5A);
      // Transmit on the external clock
      apb(1'b1, A_CTL, 8'h47);
      apb(1'b1, A_BUF, 8'hE1);
      apb(1'b1, A_CTL, 8'h87);
      ext_go = 1'b1;
      wait_rises(8);
      check({sck_oe, rx_byte}, 9'h0E1);
      // Start left set, nothing written: dummy byte, then the run ends
      ext_go = 1'b0;
      @(posedge pclk);
      ext_go = 1'b1;
      wait_rises(8);
      repeat (8) @(posedge pclk);
      apb(1'b0, A_STAT, 8'h00);
      check(rd, 0);
      apb(1'b1, A_CTL, 8'h47);
      // Processor idle with the idle bit clear holds the clock
      apb(1'b1, A_CTL, 8'h40);
      apb(1'b1, A_BUF, 8'h33);
      apb(1'b1, A_IDLE, 8'h00);
      cpu_idle <= 1'b1;
      apb(1'b1, A_CTL, 8'h80);
      stall_chk;
      cpu_idle <= 1'b0;
      wait_rises(8);
      check(rx_byte, 8'h33);
      final_report;
   end
endmodule
`default_nettype wire
